// ===== rtl/mqc_pkg.sv
// Constants and types for the meter error queue and trigger checker
package mqc_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_COUNTS = 8'h08;
  localparam logic [7:0] REG_NUM    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_ERRQ   = 8'h14;
  // Command opcodes written to REG_CMD[3:0]
  localparam logic [3:0] OP_INIT    = 4'h1;
  localparam logic [3:0] OP_READ    = 4'h2;
  localparam logic [3:0] OP_MEASURE = 4'h3;
  localparam logic [3:0] OP_BUS_TRG = 4'h4;
  localparam logic [3:0] OP_FETCH   = 4'h5;
  localparam logic [3:0] OP_CLS     = 4'h6;
  localparam logic [3:0] OP_RST     = 4'h7;
  localparam logic [3:0] OP_DEV_CLR = 4'h8;
  localparam logic [3:0] OP_TALK    = 4'h9;
  localparam logic [3:0] OP_QUERY   = 4'ha;
  localparam logic [3:0] OP_REPLY_OVF = 4'hb;
  localparam logic [3:0] OP_CONFIG  = 4'hc;
  localparam logic [3:0] OP_MATH_ON = 4'hd;
  localparam logic [3:0] OP_REF_LATCH = 4'he;
  // REG_CFG, REG_COUNTS and REG_NUM field positions
  localparam int CFG_SRC_LSB    = 0;
  localparam int CFG_REMOTE     = 2;
  localparam int CFG_AUTORANGE  = 3;
  localparam int CFG_FIXED_RES  = 4;
  localparam int CFG_RANGE_10A  = 5;
  localparam int CFG_MATH_BAD   = 6;
  localparam int CFG_MATH_ON    = 7;
  localparam int COUNTS_TRIG_LSB = 16;
  localparam int NUM_DIGITS_LSB  = 16;
  // Trigger sources
  localparam logic [1:0] SRC_IMM = 2'h0;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  // Reset values
  localparam logic [1:0]  RST_SRC       = SRC_IMM;
  localparam logic [15:0] RST_COUNT     = 16'h0001;
  // Limits
  localparam logic [4:0]  Q_DEPTH       = 5'h14;
  localparam logic [4:0]  Q_LAST        = 5'h13;
  localparam logic [31:0] MEM_LIMIT     = 32'h000007d0;
  localparam logic [15:0] EXP_LIMIT     = 16'h7d00;
  localparam logic [15:0] DIGIT_LIMIT   = 16'h00ff;
  // Error codes, signed 16-bit
  localparam logic [15:0] E_NONE        = 16'h0000;
  localparam logic [15:0] E_NUM_OVF     = 16'hff85;
  localparam logic [15:0] E_DIGITS      = 16'hff84;
  localparam logic [15:0] E_TRG_IGN     = 16'hff2d;
  localparam logic [15:0] E_INIT_IGN    = 16'hff2b;
  localparam logic [15:0] E_DEADLOCK    = 16'hff2a;
  localparam logic [15:0] E_SETTINGS    = 16'hff23;
  localparam logic [15:0] E_STALE       = 16'hff1a;
  localparam logic [15:0] E_TOO_MANY    = 16'hfea2;
  localparam logic [15:0] E_Q_INTR      = 16'hfe66;
  localparam logic [15:0] E_Q_UNTERM    = 16'hfe5c;
  localparam logic [15:0] E_Q_DEADLOCK  = 16'hfe52;
  localparam logic [15:0] E_NO_MEMORY   = 16'h0213;
  localparam logic [15:0] E_OVLD_REF    = 16'h021c;
  localparam logic [15:0] E_LOCAL       = 16'h0226;
  // Trigger state machine
  typedef enum logic [2:0] {
    TS_IDLE = 3'b001,
    TS_WAIT = 3'b010,
    TS_MEAS = 3'b100
  } mqc_trig_t;
  // Whole state of the checker
  typedef struct packed {
    mqc_trig_t         trig_state;
    logic [1:0]        src;
    logic              remote;
    logic              autorange;
    logic              fixed_res;
    logic              range_10a;
    logic              math_bad;
    logic              math_on;
    logic              read_mode;
    logic [15:0]       sample_cnt;
    logic [15:0]       trig_cnt;
    logic [19:0][15:0] q_mem;
    logic [4:0]        wr_ptr;
    logic [4:0]        rd_ptr;
    logic [4:0]        q_cnt;
    logic              q_ovf;
    logic              err_led;
    logic              beep;
    logic              meas_start;
    logic              fetch_copy;
    logic              meas_pause;
    logic              hreadyout;
    logic [31:0]       hrdata;
    logic              wr_pend;
    logic [7:0]        wr_addr;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_prev;
  } mqc_state_t;
endpackage : mqc_pkg

// ===== rtl/mqc_checker.sv
// Error queue and trigger acceptance checker with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module mqc_checker (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic               ext_trig,
  input  wire logic               meas_done,
  input  wire logic               mem_empty,
  input  wire logic               outbuf_pending,
  input  wire logic               outbuf_full,
  input  wire logic               inbuf_full,
  input  wire logic               ref_overload,
  output logic                    err_led,
  output logic                    beep,
  output logic                    meas_start,
  output logic                    fetch_copy,
  output logic                    meas_pause,
  output logic                    math_on,
  output mqc_pkg::mqc_trig_t      trig_state
);
  import mqc_pkg::*;

  mqc_state_t s_q;
  mqc_state_t s_d;
  logic       push_en;
  logic [15:0] push_code;
  logic       pop_en;
  logic       cls_en;

  // Circular pointer step; queue depth is not a power of two
  function automatic logic [4:0] ptr_next(input logic [4:0] p);
    ptr_next = (p == Q_LAST) ? 5'h00 : p + 5'h01;
  endfunction : ptr_next

  function automatic logic [4:0] ptr_prev(input logic [4:0] p);
    ptr_prev = (p == 5'h00) ? Q_LAST : p - 5'h01;
  endfunction : ptr_prev

  // Next-state logic for bus, trigger machine, checks and queue
  always_comb begin
    logic        arm;
    logic        trg_take;
    logic [31:0] product;
    s_d        = s_q;
    push_en    = 1'b0;
    push_code  = E_NONE;
    pop_en     = 1'b0;
    cls_en     = 1'b0;
    arm        = 1'b0;
    trg_take   = 1'b0;
    product    = s_q.sample_cnt * s_q.trig_cnt;
    s_d.beep       = 1'b0;
    s_d.meas_start = 1'b0;
    s_d.fetch_copy = 1'b0;
    s_d.hreadyout  = 1'b1;
    // External trigger pin: two stages, then edge against a third
    s_d.ext_s1   = ext_trig;
    s_d.ext_s2   = s_q.ext_s1;
    s_d.ext_prev = s_q.ext_s2;
    // Address phase: zero wait states, read data prepared one edge early
    s_d.wr_pend = hsel && htrans[1] && hready && hwrite;
    s_d.wr_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        REG_CFG:    s_d.hrdata = {24'h000000, s_q.math_on, s_q.math_bad, s_q.range_10a,
                                  s_q.fixed_res, s_q.autorange, s_q.remote, s_q.src};
        REG_COUNTS: s_d.hrdata = {s_q.trig_cnt, s_q.sample_cnt};
        REG_STATUS: s_d.hrdata = {17'h00000, s_q.q_ovf, 1'b0, s_q.q_cnt,
                                  s_q.meas_pause, s_q.read_mode, 1'b0, s_q.err_led,
                                  1'b0, s_q.trig_state};
        REG_ERRQ: begin
          // Reading the queue removes the oldest entry
          if (s_q.q_cnt != 5'h00) begin
            s_d.hrdata = {{16{s_q.q_mem[s_q.rd_ptr][15]}}, s_q.q_mem[s_q.rd_ptr]};
            pop_en     = 1'b1;
          end else begin
            s_d.hrdata = {16'h0000, E_NONE};
          end
        end
        default:    s_d.hrdata = 32'h00000000;
      endcase
    end
    // Data phase of writes
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        REG_CFG: begin
          s_d.src       = hwdata[CFG_SRC_LSB +: 2];
          s_d.remote    = hwdata[CFG_REMOTE];
          s_d.autorange = hwdata[CFG_AUTORANGE];
          s_d.fixed_res = hwdata[CFG_FIXED_RES];
          s_d.range_10a = hwdata[CFG_RANGE_10A];
          s_d.math_bad  = hwdata[CFG_MATH_BAD];
          s_d.math_on   = hwdata[CFG_MATH_ON];
        end
        REG_COUNTS: begin
          s_d.sample_cnt = hwdata[15:0];
          s_d.trig_cnt   = hwdata[COUNTS_TRIG_LSB +: 16];
        end
        REG_NUM: begin
          // Exponent magnitude below, significant digit count above
          if (hwdata[15:0] > EXP_LIMIT) begin
            push_en = 1'b1; push_code = E_NUM_OVF;
          end else if (hwdata[NUM_DIGITS_LSB +: 16] > DIGIT_LIMIT) begin
            push_en = 1'b1; push_code = E_DIGITS;
          end
        end
        REG_CMD: begin
          case (hwdata[3:0])
            OP_INIT, OP_READ, OP_MEASURE: begin
              if (hwdata[3:0] == OP_READ && !s_q.remote) begin
                push_en = 1'b1; push_code = E_LOCAL;
              end else if (hwdata[3:0] == OP_READ && s_q.src == SRC_BUS) begin
                push_en = 1'b1; push_code = E_DEADLOCK;
              end else if (s_q.trig_state != TS_IDLE) begin
                push_en = 1'b1; push_code = E_INIT_IGN;
              end else if (hwdata[3:0] != OP_READ && product > MEM_LIMIT) begin
                push_en = 1'b1; push_code = E_NO_MEMORY;
              end else begin
                arm = 1'b1;
                s_d.read_mode = (hwdata[3:0] == OP_READ);
              end
            end
            OP_BUS_TRG: begin
              // Only a waiting machine with bus source may take it
              if (s_q.trig_state == TS_WAIT && s_q.src == SRC_BUS) begin
                trg_take = 1'b1;
              end else begin
                push_en = 1'b1; push_code = E_TRG_IGN;
              end
            end
            OP_FETCH: begin
              if (mem_empty) begin
                push_en = 1'b1; push_code = E_STALE;
              end else begin
                s_d.fetch_copy = 1'b1;
              end
            end
            OP_CLS:     cls_en = 1'b1;
            OP_RST: begin
              // Instrument reset restores source, counts, math and trigger state but keeps the queue
              s_d.src        = RST_SRC;
              s_d.sample_cnt = RST_COUNT;
              s_d.trig_cnt   = RST_COUNT;
              s_d.math_on    = 1'b0;
              s_d.trig_state = TS_IDLE;
            end
            OP_DEV_CLR: s_d.trig_state = TS_IDLE;
            OP_TALK: begin
              if (!outbuf_pending) begin
                push_en = 1'b1; push_code = E_Q_UNTERM;
              end
            end
            OP_QUERY: begin
              if (outbuf_pending) begin
                push_en = 1'b1; push_code = E_Q_INTR;
              end
            end
            OP_REPLY_OVF: begin
              // Execution carries on; the reply itself is dropped outside
              if (inbuf_full) begin
                push_en = 1'b1; push_code = E_Q_DEADLOCK;
              end
            end
            OP_CONFIG: begin
              if ((s_q.autorange && s_q.fixed_res) || (s_q.autorange && s_q.range_10a)) begin
                push_en = 1'b1; push_code = E_SETTINGS;
              end
            end
            OP_MATH_ON: begin
              s_d.math_on = 1'b1;
              if (s_q.math_bad) begin
                push_en = 1'b1; push_code = E_SETTINGS;
              end
            end
            OP_REF_LATCH: begin
              if (ref_overload) begin
                push_en = 1'b1; push_code = E_OVLD_REF;
                s_d.math_on = 1'b0;
              end
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // Trigger machine; immediate and external sources fire on their own
    if (s_q.trig_state == TS_WAIT) begin
      if (s_q.src == SRC_IMM) trg_take = 1'b1;
      if (s_q.src == SRC_EXT && s_q.ext_s2 && !s_q.ext_prev) trg_take = 1'b1;
    end
    case (s_q.trig_state)
      TS_IDLE: if (arm) s_d.trig_state = TS_WAIT;
      TS_WAIT: begin
        if (trg_take && s_d.trig_state == TS_WAIT) begin
          s_d.trig_state = TS_MEAS;
          s_d.meas_start = 1'b1;
        end
      end
      TS_MEAS: if (meas_done && s_d.trig_state == TS_MEAS) s_d.trig_state = TS_IDLE;
      default: s_d.trig_state = TS_IDLE;
    endcase
    // Readings stall while a read-mode host leaves the buffer full
    s_d.meas_pause = (s_d.trig_state == TS_MEAS) && s_d.read_mode && outbuf_full;
    // Queue: removal first, so a full queue frees a slot before a store
    if (pop_en) begin
      s_d.rd_ptr = ptr_next(s_q.rd_ptr);
      s_d.q_cnt  = s_q.q_cnt - 5'h01;
      s_d.q_ovf  = 1'b0;
    end
    if (cls_en) begin
      s_d.rd_ptr = 5'h00;
      s_d.wr_ptr = 5'h00;
      s_d.q_cnt  = 5'h00;
      s_d.q_ovf  = 1'b0;
    end
    if (push_en) begin
      s_d.beep = 1'b1;
      if (s_d.q_cnt != Q_DEPTH) begin
        s_d.q_mem[s_d.wr_ptr] = push_code;
        s_d.wr_ptr = ptr_next(s_d.wr_ptr);
        s_d.q_cnt  = s_d.q_cnt + 5'h01;
      end else if (!s_d.q_ovf) begin
        s_d.q_mem[ptr_prev(s_d.wr_ptr)] = E_TOO_MANY;
        s_d.q_ovf = 1'b1;
      end
      // Otherwise discarded until the host reads entries out
    end
    s_d.err_led = (s_d.q_cnt != 5'h00);
  end

  // State register; reset empties the queue
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q            <= '0;
      s_q.trig_state <= TS_IDLE;
      s_q.src        <= RST_SRC;
      s_q.sample_cnt <= RST_COUNT;
      s_q.trig_cnt   <= RST_COUNT;
      s_q.hreadyout  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output but hresp straight from the state register; hresp is tied low
  assign hreadyout  = s_q.hreadyout;
  assign hresp      = 1'b0;
  assign hrdata     = s_q.hrdata;
  assign err_led    = s_q.err_led;
  assign beep       = s_q.beep;
  assign meas_start = s_q.meas_start;
  assign fetch_copy = s_q.fetch_copy;
  assign meas_pause = s_q.meas_pause;
  assign math_on    = s_q.math_on;
  assign trig_state = s_q.trig_state;

  // Checks on the design's own behaviour
  beep_per_error_a: assert property (@(posedge core_clk) disable iff (!resetn)
    push_en |=> beep ##1 (beep == $past(push_en)))
    else $error("beep not pulsed once per error");

  led_tracks_q_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 err_led == (s_q.q_cnt != 5'h00))
    else $error("error indicator disagrees with queue");

  start_from_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(meas_start) |-> $past(s_q.trig_state) == TS_WAIT && trig_state == TS_MEAS)
    else $error("trigger accepted outside wait state");

  full_overwrite_a: assert property (@(posedge core_clk) disable iff (!resetn)
    push_en && !pop_en && !cls_en && s_q.q_cnt == Q_DEPTH && !s_q.q_ovf
    |=> s_q.q_ovf && s_q.q_mem[ptr_prev(s_q.wr_ptr)] == E_TOO_MANY && s_q.q_cnt == Q_DEPTH)
    else $error("overflow code not placed in newest entry");

  empty_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == REG_ERRQ && s_q.q_cnt == 5'h00
    |=> hrdata == 32'h00000000 && $stable(s_q.rd_ptr))
    else $error("empty queue read not answered with zero");

  clear_status_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cls_en && !push_en |=> s_q.q_cnt == 5'h00 ##1 !err_led)
    else $error("clear status left entries");

  busy_arm_a: assert property (@(posedge core_clk) disable iff (!resetn)
    push_en && push_code == E_INIT_IGN |-> s_q.trig_state != TS_IDLE ##1 trig_state != TS_WAIT
      || $past(s_q.trig_state) == TS_WAIT)
    else $error("busy arm flagged from idle");

  pause_full_a: assert property (@(posedge core_clk) disable iff (!resetn)
    meas_pause |-> trig_state == TS_MEAS && s_q.read_mode && $past(outbuf_full))
    else $error("pause without full output buffer");

  pop_clears_ovf_a: assert property (@(posedge core_clk) disable iff (!resetn)
    pop_en && !push_en |=> !s_q.q_ovf && s_q.q_cnt == $past(s_q.q_cnt) - 5'h01)
    else $error("removal did not clear overflow");

  // Command write in its data phase; shortens the command checks below
  logic       cmd_wr;
  logic [3:0] cmd_op;
  assign cmd_wr = s_q.wr_pend && (s_q.wr_addr == REG_CMD);
  assign cmd_op = hwdata[3:0];

  trig_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_BUS_TRG && !(s_q.trig_state == TS_WAIT && s_q.src == SRC_BUS)
    |-> push_en && push_code == E_TRG_IGN)
    else $error("refused trigger not reported");

  read_deadlock_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_READ && s_q.remote && s_q.src == SRC_BUS
    |-> push_en && push_code == E_DEADLOCK)
    else $error("read with bus source not reported");

  local_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_READ && !s_q.remote
    |-> push_en && push_code == E_LOCAL)
    else $error("read in local mode not reported");

  arm_to_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && (cmd_op == OP_INIT || cmd_op == OP_MEASURE) && s_q.trig_state == TS_IDLE
    && s_q.sample_cnt * s_q.trig_cnt <= MEM_LIMIT |=> trig_state == TS_WAIT)
    else $error("arm from idle did not reach wait");

  mem_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_INIT && s_q.trig_state == TS_IDLE
    && s_q.sample_cnt * s_q.trig_cnt > MEM_LIMIT
    |-> push_en && push_code == E_NO_MEMORY ##1 trig_state == TS_IDLE)
    else $error("oversized acquisition was armed");

  stale_fetch_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_FETCH && mem_empty
    |-> push_en && push_code == E_STALE ##1 !fetch_copy)
    else $error("fetch from empty memory not reported");

  fetch_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_FETCH && !mem_empty |=> fetch_copy)
    else $error("fetch did not copy readings");

  ovld_ref_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_REF_LATCH && ref_overload
    |-> push_en && push_code == E_OVLD_REF ##1 !math_on)
    else $error("overload reference accepted");

  exp_limit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    s_q.wr_pend && s_q.wr_addr == REG_NUM && hwdata[15:0] > EXP_LIMIT
    |-> push_en && push_code == E_NUM_OVF)
    else $error("exponent overflow not reported");

  reset_keeps_q_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_RST && !pop_en
    |=> $stable(s_q.q_cnt) && $stable(s_q.rd_ptr))
    else $error("instrument reset changed the queue");

  oldest_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == REG_ERRQ && s_q.q_cnt != 5'h00
    && !cls_en |=> s_q.rd_ptr == ptr_next($past(s_q.rd_ptr)) && hrdata[31:16] == {16{hrdata[15]}})
    else $error("queue read did not take oldest entry");

  dev_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_wr && cmd_op == OP_DEV_CLR |=> trig_state == TS_IDLE)
    else $error("device clear did not idle the trigger");
endmodule : mqc_checker
`default_nettype wire

// ===== testbench/mqc_host_model.sv
// Remote host model: AHB-Lite master issuing single word transfers
`timescale 1ns/10ps
`default_nettype none
module mqc_host_model (
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var logic         hsel,
  output var logic [31:0]  haddr,
  output var logic [1:0]   htrans,
  output var logic         hwrite,
  output var logic [2:0]   hsize,
  output var logic [31:0]  hwdata
);
  // Bus idle at start; released lines carry inverted values so stale data cannot pass
  initial begin
    hsel   = 1'b0;
    haddr  = 32'hffffffff;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'hffffffff;
  end

  // One whole-word transfer; every wait is ended by the bench timeout if the slave hangs
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= w ? d : ~d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : mqc_host_model
`default_nettype wire

// ===== testbench/meter_error_queue_trigger_checker_bench.sv
// Self-checking bench for the error queue and trigger checker
`timescale 1ns/10ps
`default_nettype none
module meter_error_queue_trigger_checker_bench;
  import mqc_pkg::*;
  logic core_clk, resetn, hsel, hwrite, hreadyout, hresp;
  logic ext_trig, meas_done, mem_empty, outbuf_pending, outbuf_full, inbuf_full;
  logic ref_overload, err_led, beep, meas_start, fetch_copy, meas_pause, math_on;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  mqc_trig_t   trig_state;
  int mismatches, total_checks, cyc, starts, copies, seed;
  int q[$];
  bit ovf;

  mqc_checker i_mqc_checker (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_trig(ext_trig), .meas_done(meas_done), .mem_empty(mem_empty),
    .outbuf_pending(outbuf_pending), .outbuf_full(outbuf_full), .inbuf_full(inbuf_full),
    .ref_overload(ref_overload), .err_led(err_led), .beep(beep), .meas_start(meas_start),
    .fetch_copy(fetch_copy), .meas_pause(meas_pause), .math_on(math_on),
    .trig_state(trig_state));
  mqc_host_model u_host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Pulse tallies and hang guard; a few hundred cycles are expected
  always @(posedge core_clk) begin
    if (meas_start === 1'b1) starts <= starts + 1;
    if (fetch_copy === 1'b1) copies <= copies + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Queue model: full queue turns newest into -350, then discards until a pop
  function automatic void push(input int c);
    if (ovf) return;
    if (q.size() == 20) begin
      q[19] = -350;
      ovf = 1'b1;
    end
    else q.push_back(c);
  endfunction : push

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input int code);
    logic [31:0] r;
    u_host.xfer(1'b1, {24'h0, a}, d, r);
    if (code != 0) push(code);
    settle(1);
    chk("beep", {31'h0, beep}, {31'h0, code != 0});
    chk("err_led", {31'h0, err_led}, {31'h0, q.size() != 0});
  endtask : wr_chk

  task automatic pop_chk();
    logic [31:0] r;
    int e;
    e = 0;
    u_host.xfer(1'b0, {24'h0, REG_ERRQ}, 32'h0, r);
    if (q.size() != 0) begin
      e = q.pop_front();
      ovf = 1'b0;
    end
    chk("errq", r, 32'(e));
  endtask : pop_chk

  task automatic drain();
    while (q.size() != 0) pop_chk();
    pop_chk();
    settle(1);
    chk("led_off", {31'h0, err_led}, 32'h0);
  endtask : drain

  task automatic state_chk(input mqc_trig_t s);
    chk("trig_state", {29'h0, trig_state}, {29'h0, s});
  endtask : state_chk

  task automatic end_meas();
    @(posedge core_clk) meas_done <= 1'b1;
    @(posedge core_clk) meas_done <= 1'b0;
    settle(2);
    state_chk(TS_IDLE);
  endtask : end_meas

  // Main sequence: environment inputs change by NBA just after a rising edge
  initial begin
    logic [31:0] r;
    seed = 17;
    {resetn, ext_trig, meas_done, mem_empty, outbuf_pending} = 5'b0;
    {outbuf_full, inbuf_full, ref_overload} = 3'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    u_host.xfer(1'b0, {24'h0, REG_CFG}, 32'h0, r);
    chk("cfg_rst", r, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    u_host.xfer(1'b0, {24'h0, REG_COUNTS}, 32'h0, r);
    chk("counts_rst", r, 32'h00010001);
    pop_chk();
    wr_chk(REG_CMD, {28'h0, OP_BUS_TRG}, -211);
    wr_chk(REG_CFG, 32'h4, 0);
    wr_chk(REG_CMD, {28'h0, OP_INIT}, 0);
    settle(2);
    state_chk(TS_MEAS);
    chk("starts", 32'(starts), 32'd1);
    wr_chk(REG_CMD, {28'h0, OP_INIT}, -213);
    wr_chk(REG_CMD, {28'h0, OP_DEV_CLR}, 0);
    state_chk(TS_IDLE);
    // Bus source: trigger counts only once armed
    wr_chk(REG_CFG, 32'h5, 0);
    wr_chk(REG_CMD, {28'h0, OP_READ}, -214);
    wr_chk(REG_CMD, {28'h0, OP_MEASURE}, 0);
    state_chk(TS_WAIT);
    wr_chk(REG_CMD, {28'h0, OP_BUS_TRG}, 0);
    settle(1);
    chk("starts", 32'(starts), 32'd2);
    end_meas();
    wr_chk(REG_CFG, 32'h0, 0);
    wr_chk(REG_CMD, {28'h0, OP_READ}, 550);
    // External source, synchroniser delay allowed for
    wr_chk(REG_CFG, 32'h6, 0);
    wr_chk(REG_CMD, {28'h0, OP_INIT}, 0);
    settle(3);
    state_chk(TS_WAIT);
    @(posedge core_clk) ext_trig <= 1'b1;
    settle(6);
    chk("starts", 32'(starts), 32'd3);
    @(posedge core_clk) ext_trig <= 1'b0;
    end_meas();
    // Read mode stalls while the output buffer is full
    wr_chk(REG_CFG, 32'h4, 0);
    @(posedge core_clk) outbuf_full <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_READ}, 0);
    settle(4);
    chk("pause", {31'h0, meas_pause}, 32'h1);
    @(posedge core_clk) outbuf_full <= 1'b0;
    settle(3);
    chk("pause", {31'h0, meas_pause}, 32'h0);
    end_meas();
    wr_chk(REG_COUNTS, 32'h000303e8, 0);
    wr_chk(REG_CMD, {28'h0, OP_INIT}, 531);
    wr_chk(REG_COUNTS, 32'h000107d0, 0);
    wr_chk(REG_CMD, {28'h0, OP_INIT}, 0);
    settle(2);
    end_meas();
    @(posedge core_clk) mem_empty <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_FETCH}, -230);
    @(posedge core_clk) mem_empty <= 1'b0;
    wr_chk(REG_CMD, {28'h0, OP_FETCH}, 0);
    settle(1);
    chk("copies", 32'(copies), 32'd1);
    // Number limits: exact bounds pass, one over fails
    wr_chk(REG_NUM, 32'h00007d01, -123);
    wr_chk(REG_NUM, 32'h01000000, -124);
    wr_chk(REG_NUM, 32'h00ff7d00, 0);
    repeat (4) begin
      r = $random(seed);
      wr_chk(REG_NUM, {8'h00, r[23:16], 2'b00, r[13:0]}, 0);
    end
    @(posedge core_clk) outbuf_pending <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_QUERY}, -410);
    @(posedge core_clk) outbuf_pending <= 1'b0;
    wr_chk(REG_CMD, {28'h0, OP_TALK}, -420);
    @(posedge core_clk) inbuf_full <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_REPLY_OVF}, -430);
    @(posedge core_clk) inbuf_full <= 1'b0;
    wr_chk(REG_CMD, {28'h0, OP_REPLY_OVF}, 0);
    wr_chk(REG_CFG, 32'h1c, 0);
    wr_chk(REG_CMD, {28'h0, OP_CONFIG}, -221);
    wr_chk(REG_CFG, 32'h2c, 0);
    wr_chk(REG_CMD, {28'h0, OP_CONFIG}, -221);
    wr_chk(REG_CFG, 32'h44, 0);
    wr_chk(REG_CMD, {28'h0, OP_MATH_ON}, -221);
    chk("math_on", {31'h0, math_on}, 32'h1);
    @(posedge core_clk) ref_overload <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_REF_LATCH}, 540);
    chk("math_on", {31'h0, math_on}, 32'h0);
    @(posedge core_clk) ref_overload <= 1'b0;
    wr_chk(REG_CMD, {28'h0, OP_RST}, 0);
    drain();
    // Overflow: 22 errors into 20 places, then one pop reopens the queue
    repeat (22) wr_chk(REG_CMD, {28'h0, OP_BUS_TRG}, -211);
    u_host.xfer(1'b0, {24'h0, REG_STATUS}, 32'h0, r);
    chk("status_ovf", r, 32'h00005411);
    pop_chk();
    @(posedge core_clk) mem_empty <= 1'b1;
    wr_chk(REG_CMD, {28'h0, OP_FETCH}, -230);
    drain();
    repeat (3) wr_chk(REG_CMD, {28'h0, OP_BUS_TRG}, -211);
    q.delete();
    ovf = 1'b0;
    wr_chk(REG_CMD, {28'h0, OP_CLS}, 0);
    pop_chk();
    print_verdict();
  end
endmodule : meter_error_queue_trigger_checker_bench
`default_nettype wire
